//--- design/gic_top.sv
/*
  General pin block: three open-drain pins with output, interrupt, converter control
  and conversion trigger roles; host configuration arrives on the link clock.
  Assumes the host side holds CFG stable while CFG_WR is high and both resets overlap.
*/
`timescale 1ns/100ps
`include "gic_map.svh"
module gic_top (
  input  wire logic             SYS_CLK,
  input  wire logic             RESETN,
  input  wire logic             LINK_CLK,
  input  wire logic             LINK_RESETN,
  input  wire logic             CFG_WR,
  input  wire gic_pkg::gic_cfg_t CFG,
  output logic                  CFG_BUSY,
  input  wire logic             RD_STROBE,
  output logic [7:0]            PIN_LEVEL,
  input  wire logic [2:0]       PIN_IN,
  output logic [2:0]            PIN_OUT,
  output logic [2:0]            PIN_OE,
  input  wire logic             UVLO,
  output logic                  INT_N,
  output logic                  BUCK_ONE_EN,
  output logic                  BUCK_TWO_EN,
  output logic                  BUCK_STANDBY,
  output logic                  ADC_TRIGGER
);

  // link domain
  gic_pkg::gic_cfg_t cfg_hold_reg;
  logic              req_tgl_reg;
  logic              rd_tgl_reg;
  logic              ack_link_s;
  logic [2:0]        level_link_s;

  // system domain
  gic_pkg::gic_cfg_t    cfg_reg;
  gic_pkg::gic_pin_cfg_t pcfg [3];
  logic                 req_sys_s;
  logic                 req_seen_reg;
  logic                 ack_tgl_reg;
  logic                 rd_sys_s;
  logic                 rd_seen_reg;
  logic                 rd_pulse;
  logic                 cfg_load;
  logic [2:0]           pin_s;
  logic [2:0]           pin_prev_reg;
  logic [2:0]           edge_sel;
  logic [2:0]           edge_opp;
  logic                 uvlo_s;
  logic [1:0]           first_reg;
  logic [1:0]           int_reg;
  logic [1:0]           int_next;
  logic [2:0]           level_reg;

  function automatic logic edge_hit(input logic now, input logic prev, input logic rise);
    edge_hit = rise ? (now & ~prev) : (~now & prev);
  endfunction : edge_hit

  function automatic logic level_hit(input logic now, input logic active_high);
    level_hit = (now == active_high);
  endfunction : level_hit

  // ---- link side: configuration handshake, read event, status
  assign CFG_BUSY = req_tgl_reg ^ ack_link_s;

  always_ff @(posedge LINK_CLK) begin
    if (!LINK_RESETN) begin
      cfg_hold_reg <= `GIC_CFG_RESET;
      req_tgl_reg  <= 1'b0;
    end else if (CFG_WR && !CFG_BUSY) begin
      // word held stable until the system side acknowledges
      cfg_hold_reg <= CFG;
      req_tgl_reg  <= ~req_tgl_reg;
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (!LINK_RESETN) begin
      rd_tgl_reg <= 1'b0;
    end else if (RD_STROBE) begin
      rd_tgl_reg <= ~rd_tgl_reg;
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (!LINK_RESETN) begin
      PIN_LEVEL <= 8'h00;
    end else begin
      PIN_LEVEL                   <= 8'h00;
      PIN_LEVEL[`GIC_LEVEL_POS_A] <= level_link_s[`GIC_PIN_A];
      PIN_LEVEL[`GIC_LEVEL_POS_B] <= level_link_s[`GIC_PIN_B];
      PIN_LEVEL[`GIC_LEVEL_POS_C] <= level_link_s[`GIC_PIN_C];
    end
  end

  gic_sync #(.WIDTH(1)) u_ack_sync (
    .clk    (LINK_CLK),
    .resetn (LINK_RESETN),
    .d      (ack_tgl_reg),
    .q      (ack_link_s)
  );

  gic_sync #(.WIDTH(3)) u_level_sync (
    .clk    (LINK_CLK),
    .resetn (LINK_RESETN),
    .d      (level_reg),
    .q      (level_link_s)
  );

  // ---- system side crossings
  gic_sync #(.WIDTH(1)) u_req_sync (
    .clk    (SYS_CLK),
    .resetn (RESETN),
    .d      (req_tgl_reg),
    .q      (req_sys_s)
  );

  gic_sync #(.WIDTH(1)) u_rd_sync (
    .clk    (SYS_CLK),
    .resetn (RESETN),
    .d      (rd_tgl_reg),
    .q      (rd_sys_s)
  );

  // pins and lockout are asynchronous; two flops before anything looks at them
  gic_sync #(.WIDTH(3)) u_pin_sync (
    .clk    (SYS_CLK),
    .resetn (RESETN),
    .d      (PIN_IN),
    .q      (pin_s)
  );

  gic_sync #(.WIDTH(1)) u_uvlo_sync (
    .clk    (SYS_CLK),
    .resetn (RESETN),
    .d      (UVLO),
    .q      (uvlo_s)
  );

  assign cfg_load = req_sys_s ^ req_seen_reg;
  assign rd_pulse = rd_sys_s ^ rd_seen_reg;

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      req_seen_reg <= 1'b0;
      ack_tgl_reg  <= 1'b0;
      rd_seen_reg  <= 1'b0;
    end else begin
      req_seen_reg <= req_sys_s;
      ack_tgl_reg  <= req_sys_s;
      rd_seen_reg  <= rd_sys_s;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      cfg_reg <= `GIC_CFG_RESET;
    end else if (cfg_load) begin
      cfg_reg <= cfg_hold_reg;
    end
  end

  assign pcfg[`GIC_PIN_A] = cfg_reg.pin_a;
  assign pcfg[`GIC_PIN_B] = cfg_reg.pin_b;
  assign pcfg[`GIC_PIN_C] = cfg_reg.pin_c;

  // ---- open-drain drivers
  always_comb begin
    for (int i = 0; i < `GIC_NUM_PINS; i++) begin
      PIN_OUT[i] = 1'b0;
      PIN_OE[i]  = pcfg[i].dir_out & ~pcfg[i].out_high;
    end
  end

  // ---- sampling and edge detection on synchronised samples
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      pin_prev_reg <= 3'h0;
      level_reg    <= 3'h0;
    end else begin
      pin_prev_reg <= pin_s;
      level_reg    <= pin_s;
    end
  end

  always_comb begin
    for (int i = 0; i < `GIC_NUM_PINS; i++) begin
      edge_sel[i] = edge_hit(pin_s[i], pin_prev_reg[i], pcfg[i].rise_sel);
      edge_opp[i] = edge_hit(pin_s[i], pin_prev_reg[i], ~pcfg[i].rise_sel);
    end
  end

  // ---- interrupt latches, pins a and b only
  always_comb begin
    for (int i = 0; i < `GIC_IRQ_PINS; i++) begin
      int_next[i] = int_reg[i];
      if (uvlo_s || pcfg[i].dir_out || !pcfg[i].irq_en) begin
        int_next[i] = 1'b0;
      end else if (rd_pulse && !first_reg[i]) begin
        int_next[i] = 1'b0;
      end
      // a fresh edge beats any clear in the same cycle
      if (!pcfg[i].dir_out && pcfg[i].irq_en && edge_sel[i]) begin
        int_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      first_reg <= 2'h0;
      int_reg   <= 2'h0;
    end else begin
      int_reg <= int_next;
      for (int i = 0; i < `GIC_IRQ_PINS; i++) begin
        if (pcfg[i].dir_out || !pcfg[i].irq_en) begin
          first_reg[i] <= 1'b0;
        end else if (edge_sel[i]) begin
          first_reg[i] <= 1'b1;
        end else if (edge_opp[i]) begin
          first_reg[i] <= 1'b0;
        end
      end
    end
  end

  // pin c has no latch at all, so it can never reach the line
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      INT_N <= 1'b1;
    end else begin
      INT_N <= ~|(int_reg & ~{pcfg[`GIC_PIN_B].irq_mask, pcfg[`GIC_PIN_A].irq_mask});
    end
  end

  // ---- converter control by level, conversion trigger by edge
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      BUCK_ONE_EN  <= 1'b0;
      BUCK_TWO_EN  <= 1'b0;
      BUCK_STANDBY <= 1'b0;
      ADC_TRIGGER  <= 1'b0;
    end else begin
      BUCK_ONE_EN  <= !pcfg[`GIC_PIN_A].dir_out && !pcfg[`GIC_PIN_A].irq_en && pcfg[`GIC_PIN_A].buck_en
                      && level_hit(pin_s[`GIC_PIN_A], pcfg[`GIC_PIN_A].rise_sel);
      BUCK_STANDBY <= !pcfg[`GIC_PIN_A].dir_out && !pcfg[`GIC_PIN_A].irq_en && pcfg[`GIC_PIN_A].stby_en
                      && level_hit(pin_s[`GIC_PIN_A], pcfg[`GIC_PIN_A].rise_sel);
      BUCK_TWO_EN  <= !pcfg[`GIC_PIN_B].dir_out && !pcfg[`GIC_PIN_B].irq_en && pcfg[`GIC_PIN_B].buck_en
                      && level_hit(pin_s[`GIC_PIN_B], pcfg[`GIC_PIN_B].rise_sel);
      ADC_TRIGGER  <= !pcfg[`GIC_PIN_C].dir_out && cfg_reg.adc_trg_en && edge_sel[`GIC_PIN_C];
    end
  end

  // ---- assertions
  property p_oe_only_output;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (PIN_OE != 3'h0) |-> ((PIN_OE & ~{pcfg[2].dir_out, pcfg[1].dir_out, pcfg[0].dir_out}) == 3'h0);
  endproperty
  a_oe_only_output: assert property (p_oe_only_output) else $error("pin driven while input");

  property p_edge_asserts_int;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (!pcfg[0].dir_out && pcfg[0].irq_en && !pcfg[0].irq_mask && edge_sel[0] && !cfg_load)
      |=> ##1 !INT_N;
  endproperty
  a_edge_asserts_int: assert property (p_edge_asserts_int) else $error("edge did not pull line low");

  property p_no_read_holds;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (int_reg[0] && !rd_pulse && !uvlo_s && !pcfg[0].dir_out && pcfg[0].irq_en) |=> int_reg[0];
  endproperty
  a_no_read_holds: assert property (p_no_read_holds) else $error("latch dropped without read");

  property p_read_needs_opposite;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (int_reg[1] && first_reg[1] && rd_pulse && !uvlo_s && !pcfg[1].dir_out && pcfg[1].irq_en) |=> int_reg[1];
  endproperty
  a_read_needs_opposite: assert property (p_read_needs_opposite) else $error("read cleared too early");

  property p_read_clears;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (int_reg[0] && !first_reg[0] && rd_pulse && !edge_sel[0] && !cfg_load) |=> !int_reg[0] ##1 (INT_N || $past(int_reg[1]));
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("edges plus read did not release");

  property p_uvlo_releases;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (uvlo_s && !edge_sel[0] && !edge_sel[1]) |=> (int_reg == 2'h0);
  endproperty
  a_uvlo_releases: assert property (p_uvlo_releases) else $error("lockout did not release line");

  property p_mask_blocks;
    @(posedge SYS_CLK) disable iff (!RESETN)
      ((int_reg & ~{pcfg[1].irq_mask, pcfg[0].irq_mask}) == 2'h0) |=> INT_N;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked request reached line");

  property p_adc_trigger;
    @(posedge SYS_CLK) disable iff (!RESETN)
      ADC_TRIGGER |-> $past(cfg_reg.adc_trg_en) && $past(edge_sel[2]) && !$past(pcfg[2].dir_out);
  endproperty
  a_adc_trigger: assert property (p_adc_trigger) else $error("trigger without enabled edge");

  property p_buck_two_level;
    @(posedge SYS_CLK) disable iff (!RESETN)
      BUCK_TWO_EN |-> ($past(pin_s[1]) == $past(pcfg[1].rise_sel)) && $past(pcfg[1].buck_en);
  endproperty
  a_buck_two_level: assert property (p_buck_two_level) else $error("converter on at wrong level");

  property p_busy_bounded;
    @(posedge LINK_CLK) disable iff (!LINK_RESETN)
      $rose(CFG_BUSY) |-> ##[1:`GIC_BUSY_MAX_LINK] !CFG_BUSY;
  endproperty
  a_busy_bounded: assert property (p_busy_bounded) else $error("configuration handshake stuck");

  property p_buck_one_level;
    @(posedge SYS_CLK) disable iff (!RESETN)
      BUCK_ONE_EN |-> ($past(pin_s[0]) == $past(pcfg[0].rise_sel)) && $past(pcfg[0].buck_en) && !$past(pcfg[0].irq_en);
  endproperty
  a_buck_one_level: assert property (p_buck_one_level) else $error("converter one on at wrong level");

  property p_standby_level;
    @(posedge SYS_CLK) disable iff (!RESETN)
      BUCK_STANDBY |-> ($past(pin_s[0]) == $past(pcfg[0].rise_sel)) && $past(pcfg[0].stby_en) && !$past(pcfg[0].irq_en);
  endproperty
  a_standby_level: assert property (p_standby_level) else $error("standby at wrong level");

  property p_output_clears;
    @(posedge SYS_CLK) disable iff (!RESETN)
      pcfg[0].dir_out |=> !int_reg[0];
  endproperty
  a_output_clears: assert property (p_output_clears) else $error("output mode kept request");

  property p_edge_sets_first;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (!pcfg[1].dir_out && pcfg[1].irq_en && edge_sel[1]) |=> first_reg[1] && int_reg[1];
  endproperty
  a_edge_sets_first: assert property (p_edge_sets_first) else $error("edge did not set both latches");

  property p_opposite_clears_first;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (!pcfg[0].dir_out && pcfg[0].irq_en && edge_opp[0]) |=> !first_reg[0];
  endproperty
  a_opposite_clears_first: assert property (p_opposite_clears_first) else $error("opposite edge kept first latch");

endmodule : gic_top

//--- include/gic_map.svh
/*
  Constants of the general pin block: pin indices, pin counts and reset values.
  Assumes that it is included by its bare name after gic_pkg has been compiled.
*/
`ifndef GIC_MAP_SVH
`define GIC_MAP_SVH

`define GIC_PIN_A 0
`define GIC_PIN_B 1
`define GIC_PIN_C 2
`define GIC_NUM_PINS 3
`define GIC_IRQ_PINS 2
// bit positions of the pin levels in the standby status byte
`define GIC_LEVEL_POS_A 5
`define GIC_LEVEL_POS_B 6
`define GIC_LEVEL_POS_C 7
// pin b: input, buck two enable, on at high; pins a and c: input, no function
`define GIC_CFG_RESET 22'h000C00
`define GIC_BUSY_MAX_LINK 8

`endif

//--- include/gic_pkg.sv
/*
  Types of the general pin block: per-pin configuration and the whole configuration word.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package gic_pkg;

  typedef struct packed {
    logic dir_out;   // 1: pin is an output
    logic out_high;  // output released high when set, pulled low when clear
    logic irq_en;    // interrupt request mode
    logic rise_sel;  // rising edge or active-high level
    logic buck_en;   // converter on/off control
    logic stby_en;   // standby control, pin a only
    logic irq_mask;  // request kept off the interrupt line
  } gic_pin_cfg_t;

  typedef struct packed {
    gic_pin_cfg_t pin_c;
    gic_pin_cfg_t pin_b;
    gic_pin_cfg_t pin_a;
    logic         adc_trg_en;  // lives with the converter delay setting
  } gic_cfg_t;

endpackage : gic_pkg

//--- design/gic_sync.sv
/*
  Two-flop level synchroniser, one per bit.
  Assumes each bit is a level that changes slowly against clk.
*/
`timescale 1ns/100ps
module gic_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : gic_sync

//--- verification/gic_pin_model.sv
/*
  Far side of the general pins: pull-ups on the wires and external drivers that can pull them low.
  Assumes the bench chooses which external drivers pull low.
*/
`timescale 1ns/100ps
module gic_pin_model (
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] ext_low,
  output logic      [2:0] pin
);
  // wired-and with a pull-up: a released wire never keeps a stale level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin[i] = (pin_oe[i] ? pin_out[i] : 1'b1) & ~ext_low[i];
    end
  end
endmodule : gic_pin_model

//--- verification/gic_top_tb.sv
/*
  Self-checking bench of the general pin block: outputs, interrupt latch, converter control, trigger.
  Assumes gic_pkg, gic_map.svh and gic_pin_model are compiled first.
*/
`timescale 1ns/100ps
module gic_top_tb;
  logic              sys_clk;
  logic              link_clk;
  logic              resetn;
  logic              cfg_wr;
  gic_pkg::gic_cfg_t cfg;
  logic              cfg_busy;
  logic              rd_strobe;
  logic [7:0]        pin_level;
  logic [2:0]        pin;
  logic [2:0]        pin_out;
  logic [2:0]        pin_oe;
  logic [2:0]        ext_low;
  logic              uvlo;
  logic              int_n;
  logic              buck_one;
  logic              buck_two;
  logic              buck_stby;
  logic              adc_trig;
  int                errors;
  int                total_checks;
  int                adc_cnt;

  gic_top u_dut (.SYS_CLK(sys_clk), .RESETN(resetn), .LINK_CLK(link_clk), .LINK_RESETN(resetn),
    .CFG_WR(cfg_wr), .CFG(cfg), .CFG_BUSY(cfg_busy), .RD_STROBE(rd_strobe), .PIN_LEVEL(pin_level),
    .PIN_IN(pin), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .UVLO(uvlo), .INT_N(int_n),
    .BUCK_ONE_EN(buck_one), .BUCK_TWO_EN(buck_two), .BUCK_STANDBY(buck_stby), .ADC_TRIGGER(adc_trig));

  gic_pin_model u_pins (.pin_oe(pin_oe), .pin_out(pin_out), .ext_low(ext_low), .pin(pin));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #24 link_clk = ~link_clk;
  end

  always @(posedge sys_clk) begin
    if (adc_trig === 1'b1) adc_cnt++;
  end

  task finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task chk(input logic [7:0] exp, input logic [7:0] act, input string msg);
    total_checks++;
    if (act !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  task wsys(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wsys

  // fields msb first: dir_out out_high irq_en rise_sel buck_en stby_en irq_mask
  task wcfg(input logic [6:0] c, input logic [6:0] b, input logic [6:0] a, input logic adc);
    int n;
    n = 0;
    @(negedge link_clk);
    cfg = {c, b, a, adc};
    cfg_wr = 1'b1;
    @(negedge link_clk);
    cfg_wr = 1'b0;
    while (cfg_busy !== 1'b0 && n < 20) begin
      @(negedge link_clk);
      n++;
    end
    if (n >= 20) begin
      errors++;
      finish_test();
    end
    wsys(8);
  endtask : wcfg

  task host_read;
    @(negedge link_clk);
    rd_strobe = 1'b1;
    @(negedge link_clk);
    rd_strobe = 1'b0;
    wsys(12);
  endtask : host_read

  task drive(input logic [2:0] v);
    @(negedge sys_clk);
    ext_low = v;
    wsys(10);
  endtask : drive

  task t_reset_defaults;
    chk(8'h01, {7'h00, int_n}, "int after reset");
    chk(8'h00, {5'h00, pin_oe}, "pins released");
    chk(8'h01, {7'h00, buck_two}, "buck two default");
    adc_cnt = 0;
    drive(3'b100);
    drive(3'b000);
    chk(8'h00, 8'(adc_cnt), "pin c default triggers");
  endtask : t_reset_defaults

  task t_outputs;
    wcfg(7'h40, 7'h40, 7'h40, 1'b0);
    chk(8'h07, {5'h00, pin_oe}, "outputs low");
    chk(8'h00, {5'h00, pin_out}, "open drain drives only low");
    wsys(80);
    chk(8'h00, pin_level, "levels low");
    wcfg(7'h60, 7'h40, 7'h60, 1'b0);
    chk(8'h02, {5'h00, pin_oe}, "mixed outputs");
    wsys(80);
    chk(8'hA0, pin_level, "levels mixed");
  endtask : t_outputs

  task t_irq(input int p, input logic r);
    logic [2:0] idle;
    logic [2:0] act;
    idle = 3'b000;
    idle[p] = r;
    act = idle ^ (3'b001 << p);
    // new edge choice first, so that moving to idle is never a selected edge of the old one
    if (p == 0) wcfg(7'h00, 7'h00, {3'b001, r, 3'b000}, 1'b0);
    else wcfg(7'h00, {3'b001, r, 3'b000}, 7'h00, 1'b0);
    drive(idle);
    chk(8'h01, {7'h00, int_n}, "int idle");
    drive(act);
    chk(8'h00, {7'h00, int_n}, "selected edge");
    host_read();
    chk(8'h00, {7'h00, int_n}, "read before opposite edge");
    drive(idle);
    chk(8'h00, {7'h00, int_n}, "two edges no read");
    drive(act);
    drive(idle);
    chk(8'h00, {7'h00, int_n}, "more edges no read");
    host_read();
    chk(8'h01, {7'h00, int_n}, "edges then read");
  endtask : t_irq

  task t_mask_and_clears;
    drive(3'b000);
    wcfg(7'h00, 7'h00, 7'h11, 1'b0);
    drive(3'b001);
    chk(8'h01, {7'h00, int_n}, "masked request");
    drive(3'b000);
    wcfg(7'h00, 7'h00, 7'h10, 1'b0);
    drive(3'b001);
    chk(8'h00, {7'h00, int_n}, "unmasked request");
    @(negedge sys_clk);
    uvlo = 1'b1;
    wsys(10);
    chk(8'h01, {7'h00, int_n}, "undervoltage clears");
    uvlo = 1'b0;
    drive(3'b000);
    wcfg(7'h00, 7'h00, 7'h10, 1'b0);
    drive(3'b001);
    chk(8'h00, {7'h00, int_n}, "request again");
    wcfg(7'h00, 7'h00, 7'h60, 1'b0);
    chk(8'h01, {7'h00, int_n}, "output mode clears");
    drive(3'b000);
  endtask : t_mask_and_clears

  task t_buck;
    wcfg(7'h00, 7'h04, 7'h0C, 1'b0);
    drive(3'b000);
    chk(8'h01, {6'h00, buck_two, buck_one}, "buck pins high");
    drive(3'b011);
    chk(8'h01, {6'h00, buck_one, buck_two}, "buck pins low");
    wcfg(7'h00, 7'h00, 7'h0A, 1'b0);
    drive(3'b000);
    chk(8'h02, {6'h00, buck_stby, buck_one}, "standby high");
    drive(3'b001);
    chk(8'h00, {7'h00, buck_stby}, "standby low");
  endtask : t_buck

  task t_pin_c;
    drive(3'b100);
    wcfg(7'h08, 7'h00, 7'h00, 1'b1);
    adc_cnt = 0;
    drive(3'b000);
    chk(8'h01, 8'(adc_cnt), "rising trigger");
    drive(3'b100);
    chk(8'h01, 8'(adc_cnt), "falling ignored");
    wcfg(7'h08, 7'h00, 7'h00, 1'b0);
    drive(3'b000);
    chk(8'h01, 8'(adc_cnt), "trigger disabled");
    wcfg(7'h18, 7'h00, 7'h00, 1'b0);
    drive(3'b100);
    drive(3'b000);
    chk(8'h01, {7'h00, int_n}, "no pin c interrupt");
  endtask : t_pin_c

  initial begin
    resetn = 1'b0;
    cfg_wr = 1'b0;
    cfg = '0;
    rd_strobe = 1'b0;
    ext_low = 3'b000;
    uvlo = 1'b0;
    errors = 0;
    total_checks = 0;
    adc_cnt = 0;
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
    wsys(10);
    t_reset_defaults();
    t_outputs();
    for (int p = 0; p < 2; p++) begin
      t_irq(p, 1'b0);
      t_irq(p, 1'b1);
    end
    t_mask_and_clears();
    t_buck();
    t_pin_c();
    finish_test();
  end
endmodule : gic_top_tb
